// >>> otg_power_pkg.sv
// Register map, field positions and reset values of the OTG power and pull control bank
package otg_power_pkg;

    // ------------------------------------------------------------
    // Register addresses (read at any of the three, write/set/clear)
    // ------------------------------------------------------------
    localparam logic [5:0] CTRL_WRITE_ADDR  = 6'h0A;
    localparam logic [5:0] CTRL_SET_ADDR    = 6'h0B;
    localparam logic [5:0] CTRL_CLEAR_ADDR  = 6'h0C;
    localparam logic [5:0] RISE_WRITE_ADDR  = 6'h0D;
    localparam logic [5:0] RISE_SET_ADDR    = 6'h0E;
    localparam logic [5:0] RISE_CLEAR_ADDR  = 6'h0F;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int EXTERNAL_OVERCURRENT_SELECT_BIT = 7;
    localparam int DRIVE_EXTERNAL_SUPPLY_BIT       = 6;
    localparam int CHARGE_BUS_POWER_BIT            = 4;
    localparam int DISCHARGE_BUS_POWER_BIT         = 3;
    localparam int MINUS_LINE_PULLDOWN_BIT         = 2;
    localparam int PLUS_LINE_PULLDOWN_BIT          = 1;
    localparam int CABLE_IDENT_PULLUP_SAMPLE_BIT   = 0;

    // ------------------------------------------------------------
    // Event status fields (rise enable uses the same positions)
    // ------------------------------------------------------------
    localparam int EVENT_WIDTH                = 5;
    localparam int CABLE_GROUND_DETECT_BIT    = 4;
    localparam int SESSION_END_FLAG_BIT       = 3;
    localparam int SESSION_VALID_FLAG_BIT     = 2;
    localparam int BUS_POWER_VALID_FLAG_BIT   = 1;
    localparam int HOST_DISCONNECT_FLAG_BIT   = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET_VALUE = 8'h06;
    localparam logic [7:0] RISE_RESET_VALUE = 8'h1F;

    typedef enum logic [1:0] {
        ACCESS_WRITE,
        ACCESS_SET,
        ACCESS_CLEAR
    } access_kind_t;

endpackage

// >>> rise_event_detector.sv
// Rising-edge event detector for the five event status flags
`timescale 1ns/100ps

module rise_event_detector (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [4:0] status_i,
    input  wire logic [4:0] enable_i,
    output logic            event_o,
    output logic [4:0]      event_status_o
);

    logic [4:0] prev_status;
    wire  [4:0] rise_hit = status_i & ~prev_status & enable_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_status    <= 5'h00;
            event_o        <= 1'b0;
            event_status_o <= 5'h00;
        end else begin
            prev_status    <= status_i;
            event_o        <= |rise_hit;
            event_status_o <= status_i;
        end
    end

endmodule

// >>> otg_power_regs.sv
// OTG power and pull control register bank with rising-edge event enables
// What this block does
// - Control register reads at 0A-0C; write at 0A, set at 0B, clear at 0C.
// - Bit 7 picks external fault pin instead of internal comparator for power-valid.
// - Bit 6 one drives active-low supply switch output low; zero keeps it high.
// - Bit 4 one charges bus supply through resistor; default off.
// - Bit 3 one discharges bus supply through resistor; default off.
// - Bit 2 connects minus-line 15k pull-down; reset value one.
// - Bit 1 connects plus-line 15k pull-down; reset value one.
// - Bit 0 connects ident pull-up and enables its sampler; default off.
// - Enabled status rises raise event_o, with the sampled flags on event_status_o.
// - Rise enable register at 0D-0F; bits 4..0 enable the five flags.
`timescale 1ns/100ps

module otg_power_regs (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [5:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       bus_power_valid_int_i,
    input  wire logic       fault_i,
    input  wire logic       session_end_i,
    input  wire logic       session_valid_i,
    input  wire logic       cable_ground_i,
    input  wire logic       host_disconnect_i,
    output logic [7:0]      reg_rdata_o,
    output logic            reg_rvalid_o,
    output logic            power_switch_n_o,
    output logic            charge_bus_power_o,
    output logic            discharge_bus_power_o,
    output logic            minus_line_pulldown_o,
    output logic            plus_line_pulldown_o,
    output logic            cable_ident_pullup_sample_o,
    output logic            bus_power_valid_o,
    output logic            event_o,
    output logic [4:0]      event_status_o
);

    // ------------------------------------------------------------
    // Register update shared by both write/set/clear triplets
    // ------------------------------------------------------------
    function automatic logic [7:0] apply_access(input logic [7:0] old_value,
                                                input logic [7:0] data,
                                                input otg_power_pkg::access_kind_t kind);
        case (kind)
            otg_power_pkg::ACCESS_WRITE: apply_access = data;
            otg_power_pkg::ACCESS_SET:   apply_access = old_value | data;
            otg_power_pkg::ACCESS_CLEAR: apply_access = old_value & ~data;
            default:                     apply_access = old_value;
        endcase
    endfunction

    logic [7:0] otg_control_reg;
    logic [7:0] rise_event_enable_reg;
    logic [4:0] event_status_reg;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire ctrl_w = reg_addr_i == otg_power_pkg::CTRL_WRITE_ADDR;
    wire ctrl_s = reg_addr_i == otg_power_pkg::CTRL_SET_ADDR;
    wire ctrl_c = reg_addr_i == otg_power_pkg::CTRL_CLEAR_ADDR;
    wire rise_w = reg_addr_i == otg_power_pkg::RISE_WRITE_ADDR;
    wire rise_s = reg_addr_i == otg_power_pkg::RISE_SET_ADDR;
    wire rise_c = reg_addr_i == otg_power_pkg::RISE_CLEAR_ADDR;
    wire ctrl_hit = ctrl_w | ctrl_s | ctrl_c;
    wire rise_hit = rise_w | rise_s | rise_c;

    wire otg_power_pkg::access_kind_t ctrl_kind =
        ctrl_s ? otg_power_pkg::ACCESS_SET :
        ctrl_c ? otg_power_pkg::ACCESS_CLEAR : otg_power_pkg::ACCESS_WRITE;
    wire otg_power_pkg::access_kind_t rise_kind =
        rise_s ? otg_power_pkg::ACCESS_SET :
        rise_c ? otg_power_pkg::ACCESS_CLEAR : otg_power_pkg::ACCESS_WRITE;

    wire [7:0] next_ctrl = (reg_wr_i && ctrl_hit)
                         ? apply_access(otg_control_reg, reg_wdata_i, ctrl_kind)
                         : otg_control_reg;
    wire [7:0] next_rise = (reg_wr_i && rise_hit)
                         ? apply_access(rise_event_enable_reg, reg_wdata_i, rise_kind)
                         : rise_event_enable_reg;

    // read at any of three addresses
    wire [7:0] next_rdata = ctrl_hit ? otg_control_reg :
                            rise_hit ? rise_event_enable_reg : 8'h00;

    wire next_power_valid = otg_control_reg[otg_power_pkg::EXTERNAL_OVERCURRENT_SELECT_BIT]
                          ? fault_i : bus_power_valid_int_i;

    // ident level reads zero while its sampler is off
    wire next_ground = cable_ground_i
                     & otg_control_reg[otg_power_pkg::CABLE_IDENT_PULLUP_SAMPLE_BIT];

    // ------------------------------------------------------------
    // Registers and pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            otg_control_reg       <= otg_power_pkg::CTRL_RESET_VALUE;
            rise_event_enable_reg <= otg_power_pkg::RISE_RESET_VALUE;
            reg_rdata_o           <= 8'h00;
            reg_rvalid_o          <= 1'b0;
        end else begin
            otg_control_reg       <= next_ctrl;
            rise_event_enable_reg <= next_rise;
            reg_rdata_o           <= reg_rd_i ? next_rdata : 8'h00;
            reg_rvalid_o          <= reg_rd_i;
        end
    end

    // Pins follow next_ctrl so they change together with the register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_switch_n_o            <= 1'b1;
            charge_bus_power_o          <= 1'b0;
            discharge_bus_power_o       <= 1'b0;
            minus_line_pulldown_o       <= 1'b1;
            plus_line_pulldown_o        <= 1'b1;
            cable_ident_pullup_sample_o <= 1'b0;
        end else begin
            power_switch_n_o            <= ~next_ctrl[otg_power_pkg::DRIVE_EXTERNAL_SUPPLY_BIT];
            charge_bus_power_o          <= next_ctrl[otg_power_pkg::CHARGE_BUS_POWER_BIT];
            discharge_bus_power_o       <= next_ctrl[otg_power_pkg::DISCHARGE_BUS_POWER_BIT];
            minus_line_pulldown_o       <= next_ctrl[otg_power_pkg::MINUS_LINE_PULLDOWN_BIT];
            plus_line_pulldown_o        <= next_ctrl[otg_power_pkg::PLUS_LINE_PULLDOWN_BIT];
            cable_ident_pullup_sample_o <= next_ctrl[otg_power_pkg::CABLE_IDENT_PULLUP_SAMPLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Event status sampling
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_status_reg  <= 5'h00;
            bus_power_valid_o <= 1'b0;
        end else begin
            event_status_reg  <= {next_ground, session_end_i, session_valid_i,
                                  next_power_valid, host_disconnect_i};
            bus_power_valid_o <= next_power_valid;
        end
    end

    // session-end rise is what the link waits on to stop discharge
    rise_event_detector u_rise (
        .clk_i          (clk_i),
        .rst_n_i        (rst_n_i),
        .status_i       (event_status_reg),
        .enable_i       (rise_event_enable_reg[4:0]),
        .event_o        (event_o),
        .event_status_o (event_status_o)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_ctrl_write;
        reg_wr_i && reg_addr_i == otg_power_pkg::CTRL_WRITE_ADDR;
    endsequence
    sequence seq_ctrl_set;
        reg_wr_i && reg_addr_i == otg_power_pkg::CTRL_SET_ADDR;
    endsequence
    sequence seq_ctrl_clear;
        reg_wr_i && reg_addr_i == otg_power_pkg::CTRL_CLEAR_ADDR;
    endsequence

    a_ctrl_full_write:
        assert property (seq_ctrl_write |=> otg_control_reg == $past(reg_wdata_i))
        else $error("control write not stored");
    a_ctrl_read_back:
        assert property (reg_rd_i && ctrl_hit && !reg_wr_i
                         |=> reg_rvalid_o && reg_rdata_o == otg_control_reg)
        else $error("control read wrong");
    a_set_only_ones:
        assert property (seq_ctrl_set
                         |=> otg_control_reg == ($past(otg_control_reg) | $past(reg_wdata_i)))
        else $error("set access wrong");
    a_clear_only_ones:
        assert property (seq_ctrl_clear
                         |=> otg_control_reg == ($past(otg_control_reg) & ~$past(reg_wdata_i)))
        else $error("clear access wrong");
    a_source_select:
        assert property (otg_control_reg[7] && fault_i && !(reg_wr_i && ctrl_hit)
                         |=> bus_power_valid_o)
        else $error("external fault source not used");
    a_switch_drive:
        assert property (seq_ctrl_set ##0 reg_wdata_i[6] |=> !power_switch_n_o ##1 1)
        else $error("supply switch not driven low");
    a_charge_follows:
        assert property (seq_ctrl_clear ##0 reg_wdata_i[4] |=> !charge_bus_power_o)
        else $error("charge not stopped");
    a_discharge_follows:
        assert property (seq_ctrl_set ##0 reg_wdata_i[3] |=> discharge_bus_power_o)
        else $error("discharge not started");
    a_pulldown_minus:
        assert property (seq_ctrl_write |=> minus_line_pulldown_o == $past(reg_wdata_i[2]))
        else $error("minus pull-down mismatch");
    a_pulldown_plus:
        assert property (seq_ctrl_clear ##0 reg_wdata_i[1] |=> !plus_line_pulldown_o)
        else $error("plus pull-down not released");
    a_ident_gate:
        assert property (!otg_control_reg[0] |=> !event_status_reg[4])
        else $error("ident sampled while disabled");
    a_rise_event:
        assert property (|(event_status_reg & ~$past(event_status_reg)
                           & rise_event_enable_reg[4:0])
                         |=> event_o && event_status_o == $past(event_status_reg))
        else $error("rising edge not reported");
    a_rise_enable_read:
        assert property (reg_rd_i && rise_hit && !reg_wr_i
                         |=> reg_rdata_o == rise_event_enable_reg)
        else $error("rise enable read wrong");

endmodule

// >>> link_model.sv
// Link-side partner issuing decoded register accesses to the bank
`timescale 1ns/100ps

module link_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [5:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o
);
    initial begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 6'h3F;
        reg_wdata_o = 8'hA5;
    end

    task automatic access(input logic rd, input logic [5:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
        @(negedge clk_i);
        reg_rd_o    = rd;
        reg_wr_o    = ~rd;
        reg_addr_o  = a;
        reg_wdata_o = d;
        @(negedge clk_i);
        reg_rd_o    = 1'b0;
        reg_wr_o    = 1'b0;
        // Idle lines flip so a stale value can never pass as held
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
        ok          = ~rd;
        q           = 8'h00;
        for (int i = 0; i < 3 && rd && !ok; i++) begin
            if (reg_rvalid_i === 1'b1) begin
                q  = reg_rdata_i;
                ok = 1'b1;
            end else begin
                @(negedge clk_i);
            end
        end
    endtask
endmodule

// >>> otg_bus_power_control_regs_tb.sv
// Self-checking bench for the OTG power and pull control bank
`timescale 1ns/100ps

module otg_bus_power_control_regs_tb;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       wr, rd, cmp = 1'b0, flt = 1'b0, send = 1'b0, sval = 1'b0;
    logic       gnd = 1'b0, hdis = 1'b0;
    logic [5:0] addr;
    logic [7:0] wdata, rdata;
    logic       rvalid, power_switch_n, chg, dis, mpd, ppd, idp, pvalid, event_o;
    logic [4:0] event_status_o;
    int         miscompares = 0;
    int         checks_done = 0;

    always #4 clk_i = ~clk_i;

    otg_power_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .bus_power_valid_int_i(cmp),
        .fault_i(flt), .session_end_i(send), .session_valid_i(sval),
        .cable_ground_i(gnd), .host_disconnect_i(hdis), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .power_switch_n_o(power_switch_n), .charge_bus_power_o(chg),
        .discharge_bus_power_o(dis), .minus_line_pulldown_o(mpd),
        .plus_line_pulldown_o(ppd), .cable_ident_pullup_sample_o(idp),
        .bus_power_valid_o(pvalid), .event_o(event_o), .event_status_o(event_status_o));

    link_model u_link (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input logic r, input logic [5:0] a, input logic [7:0] d,
                       input logic [7:0] exp);
        logic [7:0] q;
        logic       ok;
        u_link.access(r, a, d, q, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected read valid expected 1 seen %b", ok);
            close_out();
        end else if (r) begin
            chk("read data", exp, q);
        end
    endtask

    // Pin levels follow the control value on the write edge; checked two falling edges later
    task automatic pins(input logic [7:0] v);
        repeat (2) @(negedge clk_i);
        chk("pins", {2'b00, ~v[6], v[4], v[3], v[2], v[1], v[0]},
            {2'b00, power_switch_n, chg, dis, mpd, ppd, idp});
    endtask

    task automatic count_ev(output int n, output logic [4:0] s);
        n = 0;
        s = 5'h00;
        repeat (5) begin
            @(negedge clk_i);
            if (event_o === 1'b1) begin
                n++;
                s = event_status_o;
            end
        end
    endtask

    task automatic scen_reset();
        acc(1'b1, 6'h0A, 8'h00, 8'h06);
        acc(1'b1, 6'h0D, 8'h00, 8'h1F);
        pins(8'h06);
        acc(1'b1, 6'h20, 8'h00, 8'h00);
    endtask

    // set and clear touch only the ones written
    task automatic scen_wsc();
        acc(1'b0, 6'h0A, 8'h50, 8'h00);
        pins(8'h50);
        acc(1'b1, 6'h0C, 8'h00, 8'h50);
        acc(1'b0, 6'h0B, 8'h09, 8'h00);
        pins(8'h59);
        acc(1'b1, 6'h0B, 8'h00, 8'h59);
        acc(1'b0, 6'h0C, 8'h42, 8'h00);
        acc(1'b0, 6'h0B, 8'h20, 8'h00);
        acc(1'b1, 6'h0A, 8'h00, 8'h39);
        pins(8'h39);
        acc(1'b0, 6'h0A, 8'h06, 8'h00);
    endtask

    task automatic scen_src();
        cmp = 1'b1;
        pins(8'h06);
        chk("power valid", 8'h01, {7'h00, pvalid});
        acc(1'b0, 6'h0B, 8'h80, 8'h00);
        pins(8'h86);
        chk("power valid", 8'h00, {7'h00, pvalid});
        flt = 1'b1;
        cmp = 1'b0;
        pins(8'h86);
        chk("power valid", 8'h01, {7'h00, pvalid});
        acc(1'b0, 6'h0C, 8'h80, 8'h00);
        pins(8'h06);
        chk("power valid", 8'h00, {7'h00, pvalid});
    endtask

    // discharge until the session-end rise is reported
    task automatic scen_srp();
        int         n;
        logic [4:0] s;
        acc(1'b0, 6'h0D, 8'h08, 8'h00);
        acc(1'b0, 6'h0B, 8'h08, 8'h00);
        pins(8'h0E);
        sval = 1'b1;
        count_ev(n, s);
        chk("masked rise events", 8'h00, n[7:0]);
        send = 1'b1;
        count_ev(n, s);
        chk("enabled rise events", 8'h01, n[7:0]);
        chk("event status", 8'h0C, {3'b000, s});
        send = 1'b0;
        count_ev(n, s);
        chk("fall events", 8'h00, n[7:0]);
        acc(1'b0, 6'h0C, 8'h08, 8'h00);
        // supply discharged and lines idle before charging
        acc(1'b0, 6'h0B, 8'h10, 8'h00);
        pins(8'h16);
        acc(1'b1, 6'h0F, 8'h00, 8'h08);
    endtask

    // ident flag stays low until its sampler is switched on
    task automatic scen_ident();
        int         n;
        logic [4:0] s;
        acc(1'b0, 6'h0E, 8'h11, 8'h00);
        gnd = 1'b1;
        count_ev(n, s);
        chk("gated ident events", 8'h00, n[7:0]);
        chk("gated status", 8'h04, {3'b000, event_status_o});
        acc(1'b0, 6'h0B, 8'h01, 8'h00);
        count_ev(n, s);
        chk("ident rise events", 8'h01, n[7:0]);
        chk("ident rise status", 8'h14, {3'b000, s});
        hdis = 1'b1;
        count_ev(n, s);
        chk("disconnect rise events", 8'h01, n[7:0]);
        chk("disconnect status", 8'h15, {3'b000, s});
        acc(1'b1, 6'h0D, 8'h00, 8'h19);
    endtask

    initial begin
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        scen_reset();
        scen_wsc();
        scen_src();
        scen_srp();
        scen_ident();
        close_out();
    end
endmodule
